// file: hdl/irs_pkg.sv
// register map, address choices and state codes of the two-wire register target
// assumes one 125 MHz clock domain; shared by the target module and the bench
`default_nettype none
package irs_pkg;
  // *****************************
  // bus addressing
  // *****************************
  localparam logic [6:0] IRS_ADDR_NORMAL  = 7'h39;
  localparam logic [6:0] IRS_ADDR_SWAPPED = 7'h38;
  localparam logic [3:0] IRS_BYTE_BITS    = 4'h8;
  localparam logic [7:0] IRS_KEY_VALUE    = 8'h07;
  // *****************************
  // register offsets
  // *****************************
  localparam logic [7:0] IRS_FUNCTION_ENABLE   = 8'h80;
  localparam logic [7:0] IRS_SAMPLE_PERIOD     = 8'h82;
  localparam logic [7:0] IRS_LOW_THRESH_LSB    = 8'h88;
  localparam logic [7:0] IRS_LOW_THRESH_MSB    = 8'h89;
  localparam logic [7:0] IRS_HIGH_THRESH_LSB   = 8'h8A;
  localparam logic [7:0] IRS_HIGH_THRESH_MSB   = 8'h8B;
  localparam logic [7:0] IRS_IRQ_PERSISTENCE   = 8'h8C;
  localparam logic [7:0] IRS_CONFIG_ZERO       = 8'h8D;
  localparam logic [7:0] IRS_PROX_SETUP_ZERO   = 8'h8E;
  localparam logic [7:0] IRS_PROX_SETUP_ONE    = 8'h8F;
  localparam logic [7:0] IRS_REVISION_CODE     = 8'h91;
  localparam logic [7:0] IRS_PART_CODE         = 8'h92;
  localparam logic [7:0] IRS_DEVICE_STATUS     = 8'h9B;
  localparam logic [7:0] IRS_RESULT_LSB        = 8'h9C;
  localparam logic [7:0] IRS_RESULT_MSB        = 8'h9D;
  localparam logic [7:0] IRS_REVISION_CODE_TWO = 8'hA6;
  localparam logic [7:0] IRS_SOFTWARE_RESET    = 8'hA8;
  localparam logic [7:0] IRS_INTER_SAMPLE_WAIT = 8'hA9;
  localparam logic [7:0] IRS_CONFIG_EIGHT      = 8'hAA;
  localparam logic [7:0] IRS_CONFIG_THREE      = 8'hAB;
  localparam logic [7:0] IRS_CONFIG_SIX        = 8'hAE;
  localparam logic [7:0] IRS_RESULT_SMOOTHING  = 8'hB3;
  localparam logic [7:0] IRS_XTALK_OFFSET_LSB  = 8'hC0;
  localparam logic [7:0] IRS_XTALK_OFFSET_MSB  = 8'hC1;
  localparam logic [7:0] IRS_XTALK_TRIM_START  = 8'hD7;
  localparam logic [7:0] IRS_XTALK_TRIM_SETUP  = 8'hD9;
  localparam logic [7:0] IRS_XTALK_TRIM_STATE  = 8'hDC;
  localparam logic [7:0] IRS_IRQ_MASK          = 8'hDD;
  localparam logic [7:0] IRS_LOT_CODE_LSB      = 8'hE5;
  localparam logic [7:0] IRS_LOT_CODE_MSB      = 8'hE6;
  localparam logic [7:0] IRS_FACTORY_TEST_KEY  = 8'hF9;
  // status bit set by a new result, cleared by reading the status register
  localparam int unsigned IRS_STATUS_RESULT_BIT = 0;
  localparam logic [13:0] IRS_RESULT_MAX        = 14'h3FFF;

  typedef enum logic [3:0] {
    IRS_IDLE      = 4'b0000,
    IRS_ADDR      = 4'b0001,
    IRS_ADDR_ACK  = 4'b0010,
    IRS_REG       = 4'b0011,
    IRS_REG_ACK   = 4'b0100,
    IRS_WDATA     = 4'b0101,
    IRS_WDATA_ACK = 4'b0110,
    IRS_RDATA     = 4'b0111,
    IRS_RDATA_ACK = 4'b1000
  } irs_state_e;

  // software-writable registers and their reset values
  function automatic logic irs_writable(input logic [7:0] a);
    case (a)
      IRS_FUNCTION_ENABLE, IRS_SAMPLE_PERIOD, IRS_LOW_THRESH_LSB, IRS_LOW_THRESH_MSB,
      IRS_HIGH_THRESH_LSB, IRS_HIGH_THRESH_MSB, IRS_IRQ_PERSISTENCE, IRS_CONFIG_ZERO,
      IRS_PROX_SETUP_ZERO, IRS_PROX_SETUP_ONE, IRS_SOFTWARE_RESET, IRS_INTER_SAMPLE_WAIT,
      IRS_CONFIG_EIGHT, IRS_CONFIG_THREE, IRS_CONFIG_SIX, IRS_RESULT_SMOOTHING,
      IRS_XTALK_OFFSET_LSB, IRS_XTALK_OFFSET_MSB, IRS_XTALK_TRIM_START, IRS_XTALK_TRIM_SETUP,
      IRS_IRQ_MASK, IRS_FACTORY_TEST_KEY: irs_writable = 1'b1;
      default: irs_writable = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] irs_reset_value(input logic [7:0] a);
    case (a)
      IRS_SAMPLE_PERIOD:    irs_reset_value = 8'h1F;
      IRS_CONFIG_ZERO:      irs_reset_value = 8'h40;
      IRS_PROX_SETUP_ZERO:  irs_reset_value = 8'h8F;
      IRS_PROX_SETUP_ONE:   irs_reset_value = 8'h60;
      IRS_CONFIG_EIGHT:     irs_reset_value = 8'h02;
      IRS_CONFIG_THREE:     irs_reset_value = 8'h04;
      IRS_CONFIG_SIX:       irs_reset_value = 8'h3F;
      IRS_XTALK_TRIM_SETUP: irs_reset_value = 8'h50;
      default:              irs_reset_value = 8'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: hdl/irs_target.sv
// two-wire bus target with auto-incrementing register map
// assumes pins are open drain, resolved outside; result engine feeds raw samples on clk
`default_nettype none
module irs_target
  import irs_pkg::*;
#(
  parameter logic [7:0] REVISION_ID     = 8'hA5, // arbitrary value
  parameter logic [7:0] PART_ID         = 8'h5A, // arbitrary value
  parameter logic [7:0] REVISION_ID_TWO = 8'h3C, // arbitrary value
  parameter logic [7:0] LOT_LSB         = 8'h12, // arbitrary value
  parameter logic [7:0] LOT_MSB         = 8'h34  // arbitrary value
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // bus pin normally wired to the clock line
  input  wire logic        pin_a_i,
  output var  logic        pin_a_o,
  output var  logic        pin_a_oe,
  // bus pin normally wired to the data line
  input  wire logic        pin_b_i,
  output var  logic        pin_b_o,
  output var  logic        pin_b_oe,
  // measurement engine side
  input  wire logic [13:0] raw_signal,
  input  wire logic        raw_valid,
  output var  logic [7:0]  function_enable,
  output var  logic [13:0] low_threshold,
  output var  logic [13:0] high_threshold,
  output var  logic        address_settled
);

  // *****************************
  // pin synchronisers
  // *****************************
  logic [2:0] a_sync;
  logic [2:0] b_sync;
  logic       a_lvl;
  logic       b_lvl;
  logic       a_prev;
  logic       b_prev;

  // three stages, a level counts once the last two agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_sync <= 3'h7;
      b_sync <= 3'h7;
    end else begin
      a_sync <= {a_sync[1:0], pin_a_i};
      b_sync <= {b_sync[1:0], pin_b_i};
    end
  end

  // 8 ns sampling leaves ample margin at 400 kHz
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_lvl  <= 1'b1;
      b_lvl  <= 1'b1;
      a_prev <= 1'b1;
      b_prev <= 1'b1;
    end else begin
      if (a_sync[1] == a_sync[2]) a_lvl <= a_sync[2];
      if (b_sync[1] == b_sync[2]) b_lvl <= b_sync[2];
      a_prev <= a_lvl;
      b_prev <= b_lvl;
    end
  end

  // *****************************
  // address selection
  // *****************************
  logic swapped;
  logic seen_start;

  logic scl;
  logic sda;
  logic scl_prev;
  logic sda_prev;
  assign scl      = swapped ? b_lvl : a_lvl;
  assign sda      = swapped ? a_lvl : b_lvl;
  assign scl_prev = swapped ? b_prev : a_prev;
  assign sda_prev = swapped ? a_prev : b_prev;

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic raw_start_a;
  logic raw_start_b;
  // before settling, a start on either pin pair decides which pin is the clock
  assign raw_start_b = b_prev & ~b_lvl & a_lvl & a_prev;
  assign raw_start_a = a_prev & ~a_lvl & b_lvl & b_prev;
  assign start_det   = sda_prev & ~sda & scl & scl_prev;
  assign stop_det    = ~sda_prev & sda & scl & scl_prev;
  assign scl_rise    = ~scl_prev & scl;
  assign scl_fall    = scl_prev & ~scl;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      swapped         <= 1'b0;
      seen_start      <= 1'b0;
      address_settled <= 1'b0;
    end else if (!address_settled) begin
      if (!seen_start && (raw_start_a || raw_start_b)) begin
        seen_start <= 1'b1;
        swapped    <= raw_start_a;
      end else if (seen_start && stop_det) begin
        address_settled <= 1'b1;
      end
    end
  end

  logic [6:0] my_addr;
  assign my_addr = swapped ? IRS_ADDR_SWAPPED : IRS_ADDR_NORMAL;

  // *****************************
  // register store
  // *****************************
  logic [7:0]  regs [0:255];
  logic [7:0]  status;
  logic [13:0] result;
  logic [7:0]  ptr;
  logic [7:0]  shreg;
  logic        wr_en;
  logic        rd_load;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    case (a)
      IRS_REVISION_CODE:     read_reg = REVISION_ID;
      IRS_PART_CODE:         read_reg = PART_ID;
      IRS_REVISION_CODE_TWO: read_reg = REVISION_ID_TWO;
      IRS_LOT_CODE_LSB:      read_reg = LOT_LSB;
      IRS_LOT_CODE_MSB:      read_reg = LOT_MSB;
      IRS_DEVICE_STATUS:     read_reg = status;
      IRS_RESULT_LSB:        read_reg = result[7:0];
      IRS_RESULT_MSB:        read_reg = {2'b00, result[13:8]};
      default:               read_reg = irs_writable(a) ? regs[a] : 8'h00;
    endcase
  endfunction

  // signed offset: sign in bit 0 of the msb register
  function automatic logic [13:0] apply_offset(input logic [13:0] raw, input logic [8:0] off);
    logic signed [15:0] diff;
    diff = $signed({2'b00, raw}) - $signed({{7{off[8]}}, off});
    if (diff < 0) apply_offset = 14'h0000;
    else if (diff > $signed({2'b00, IRS_RESULT_MAX})) apply_offset = IRS_RESULT_MAX;
    else apply_offset = diff[13:0];
  endfunction

  // read-only offsets never land in the array, so they stay as reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 256; i++) begin
        regs[i] <= irs_reset_value(8'(i));
      end
    end else if (wr_en && irs_writable(ptr)) begin
      regs[ptr] <= shreg;
    end
  end

  // thresholds reach the engine only when the high byte lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_threshold  <= 14'h0000;
      high_threshold <= 14'h0000;
    end else if (wr_en) begin
      if (ptr == IRS_LOW_THRESH_MSB) low_threshold <= {shreg[5:0], regs[IRS_LOW_THRESH_LSB]};
      if (ptr == IRS_HIGH_THRESH_MSB) high_threshold <= {shreg[5:0], regs[IRS_HIGH_THRESH_LSB]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) function_enable <= 8'h00;
    else function_enable <= regs[IRS_FUNCTION_ENABLE];
  end

  // *****************************
  // result and status
  // *****************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result <= 14'h0000;
    end else if (raw_valid) begin
      result <= apply_offset(raw_signal, {regs[IRS_XTALK_OFFSET_MSB][0], regs[IRS_XTALK_OFFSET_LSB]});
    end
  end

  // a new result in the same cycle as the clearing read wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status <= 8'h00;
    end else begin
      if (rd_load && ptr == IRS_DEVICE_STATUS) status <= 8'h00;
      if (raw_valid) status[IRS_STATUS_RESULT_BIT] <= 1'b1;
    end
  end

  // *****************************
  // protocol engine
  // *****************************
  irs_state_e state;
  logic [3:0] bitcnt;
  logic [7:0] txbyte;
  logic       rw;
  logic       master_ack;
  logic       drive_low;
  logic       addr_hit;
  logic [7:0] rd_byte;

  assign addr_hit = address_settled && shreg[7:1] == my_addr;
  assign wr_en    = state == IRS_WDATA && scl_fall && bitcnt == IRS_BYTE_BITS;
  assign rd_load  = scl_fall && ((state == IRS_ADDR_ACK && rw) || (state == IRS_RDATA_ACK && master_ack));
  assign rd_byte  = read_reg(ptr);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      master_ack <= 1'b0;
    end else if (start_det) begin
      bitcnt <= 4'h0;
    end else if (scl_rise) begin
      shreg      <= {shreg[6:0], sda};
      bitcnt     <= bitcnt + 4'h1;
      master_ack <= ~sda;
    end else if (scl_fall && bitcnt == IRS_BYTE_BITS + 4'h1) begin
      bitcnt <= 4'h0;
    end
  end

  // pointer only moves on byte traffic; stop leaves it alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr <= 8'h00;
    end else if (state == IRS_REG && scl_fall && bitcnt == IRS_BYTE_BITS) begin
      ptr <= shreg;
    end else if (wr_en || rd_load) begin
      ptr <= ptr + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state     <= IRS_IDLE;
      rw        <= 1'b0;
      txbyte    <= 8'h00;
      drive_low <= 1'b0;
    end else if (start_det) begin
      state     <= IRS_ADDR;
      drive_low <= 1'b0;
    end else if (stop_det) begin
      state     <= IRS_IDLE;
      drive_low <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        IRS_ADDR: begin
          if (bitcnt == IRS_BYTE_BITS && addr_hit) begin
            state     <= IRS_ADDR_ACK;
            rw        <= shreg[0];
            drive_low <= 1'b1;
          end else if (bitcnt == IRS_BYTE_BITS) begin
            state <= IRS_IDLE;
          end
        end
        IRS_ADDR_ACK: begin
          if (rw) begin
            state     <= IRS_RDATA;
            txbyte    <= rd_byte;
            drive_low <= ~rd_byte[7];
          end else begin
            state     <= IRS_REG;
            drive_low <= 1'b0;
          end
        end
        IRS_REG: begin
          if (bitcnt == IRS_BYTE_BITS) begin
            state     <= IRS_REG_ACK;
            drive_low <= 1'b1;
          end
        end
        IRS_WDATA: begin
          if (bitcnt == IRS_BYTE_BITS) begin
            state     <= IRS_WDATA_ACK;
            drive_low <= 1'b1;
          end
        end
        IRS_REG_ACK, IRS_WDATA_ACK: begin
          state     <= IRS_WDATA;
          drive_low <= 1'b0;
        end
        IRS_RDATA: begin
          if (bitcnt == IRS_BYTE_BITS) begin
            state     <= IRS_RDATA_ACK;
            drive_low <= 1'b0;
          end else begin
            drive_low <= ~txbyte[3'(IRS_BYTE_BITS - 4'h1 - bitcnt)];
          end
        end
        IRS_RDATA_ACK: begin
          if (master_ack) begin
            state     <= IRS_RDATA;
            txbyte    <= rd_byte;
            drive_low <= ~rd_byte[7];
          end else begin
            state <= IRS_IDLE;
          end
        end
        default: begin
          state     <= IRS_IDLE;
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // *****************************
  // pin drivers
  // *****************************
  // clock line is never stretched, so only the data pin is ever enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_a_o  <= 1'b0;
      pin_b_o  <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      pin_a_o  <= 1'b0;
      pin_b_o  <= 1'b0;
      pin_a_oe <= drive_low & swapped;
      pin_b_oe <= drive_low & ~swapped;
    end
  end

  // *****************************
  // checks
  // *****************************
  sequence s_addr_byte;
    state == IRS_ADDR && scl_fall && bitcnt == IRS_BYTE_BITS;
  endsequence

  sequence s_reg_byte;
    state == IRS_REG && scl_fall && bitcnt == IRS_BYTE_BITS;
  endsequence

  chk_addr_normal: assert property (@(posedge clk) disable iff (sys_rst)
    s_addr_byte and (address_settled && !swapped && shreg[7:1] == IRS_ADDR_NORMAL) |=> ##1 pin_b_oe)
    else $error("normal address not acknowledged");
  chk_addr_swap: assert property (@(posedge clk) disable iff (sys_rst)
    s_addr_byte and (address_settled && swapped && shreg[7:1] == IRS_ADDR_SWAPPED) |=> ##1 pin_a_oe)
    else $error("alternate address not acknowledged");
  chk_dummy_nack: assert property (@(posedge clk) disable iff (sys_rst)
    !address_settled |-> ##1 !pin_a_oe && !pin_b_oe)
    else $error("pin driven before address settled");
  chk_ptr_load: assert property (@(posedge clk) disable iff (sys_rst)
    s_reg_byte |=> ptr == $past(shreg))
    else $error("pointer not loaded from register byte");
  chk_ptr_step: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_en || rd_load) |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not step by one");
  chk_ptr_keep: assert property (@(posedge clk) disable iff (sys_rst)
    stop_det |=> $stable(ptr) && state == IRS_IDLE)
    else $error("pointer changed at stop");
  chk_thresh_pair: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en && ptr == IRS_LOW_THRESH_MSB |=> low_threshold == {$past(shreg[5:0]), regs[IRS_LOW_THRESH_LSB]})
    else $error("low threshold not latched as a pair");
  chk_ro_ack: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en && !irs_writable(ptr) |=> ##1 (pin_a_oe || pin_b_oe))
    else $error("read-only write not acknowledged");
  chk_offset_sub: assert property (@(posedge clk) disable iff (sys_rst)
    raw_valid && regs[IRS_XTALK_OFFSET_MSB][0] == 1'b0 |=>
      result <= $past(raw_signal))
    else $error("positive offset raised the result");

endmodule
`default_nettype wire

// file: tb/irs_bus_ctrl.sv
// two-wire bus controller model: drives open-drain clock and data pulls
// assumes the bench resolves both wires with pull-ups and feeds the levels back
`default_nettype none
module irs_bus_ctrl (
  // clock
  input  wire logic clk,
  // resolved wire levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // pull-down requests
  output var  logic scl_low,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************
  // bus phases
  // ****************************
  int hp = 10; // clk cycles per bus phase
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  task automatic ph();
    repeat (hp) @(negedge clk);
  endtask
  // also a repeated start from a low clock
  task automatic start();
    repeat (2) @(negedge clk);
    sda_low = 1'h0;
    ph();
    scl_low = 1'h0;
    ph();
    sda_low = 1'h1;
    ph();
    scl_low = 1'h1;
  endtask
  task automatic stop();
    repeat (2) @(negedge clk);
    sda_low = 1'h1;
    ph();
    scl_low = 1'h0;
    ph();
    sda_low = 1'h0;
    ph();
  endtask
  // tx[0] low on the ninth bit acknowledges a read byte
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      // two cycles of hold after the clock falls
      repeat (2) @(negedge clk);
      sda_low = ~tx[i];
      ph();
      scl_low = 1'h0;
      ph();
      rx[i] = sda_i;
      scl_low = 1'h1;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// bench: two register targets on one bus, the second with swapped wires
// assumes irs_bus_ctrl as controller and pull-ups on both wires
`default_nettype none
module tb_top
  import irs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h6B; // arbitrary value
  localparam logic [7:0] PRT = 8'h2E; // arbitrary value
  localparam logic [7:0] RV2 = 8'h71; // arbitrary value
  localparam logic [7:0] LTL = 8'h0D; // arbitrary value
  localparam logic [7:0] LTH = 8'hE4; // arbitrary value
  logic        clk;
  logic        sys_rst;
  logic [13:0] raw_signal;
  logic        raw_valid;
  logic        scl_low;
  logic        sda_low;
  logic        scl;
  logic        sda;
  logic        pa_i [2];
  logic        pb_i [2];
  logic        a_oe [2];
  logic        b_oe [2];
  logic        a_o  [2];
  logic        b_o  [2];
  logic [7:0]  fe   [2];
  logic [13:0] lth  [2];
  logic [13:0] hth  [2];
  logic        setl [2];
  int          n_fail = 0;
  int          n_tests = 0;
  int          seed = 94;
  logic [7:0]  mem  [2][256];
  logic [7:0]  ptr  [2];
  logic [13:0] lt   [2];
  logic [13:0] ht   [2];
  bit          rw   [256];
  logic [7:0]  q    [$];
  logic [7:0]  rwl  [22] = '{8'h80, 8'h82, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'hA8,
                            8'hA9, 8'hAA, 8'hAB, 8'hAE, 8'hB3, 8'hC0, 8'hC1, 8'hD7, 8'hD9, 8'hDD, 8'hF9};
  // ****************************
  // bus wiring
  // ****************************
  assign scl = ~(scl_low | (a_oe[0] & ~a_o[0]) | (b_oe[1] & ~b_o[1]));
  assign sda = ~(sda_low | (b_oe[0] & ~b_o[0]) | (a_oe[1] & ~a_o[1]));
  assign pa_i[0] = scl;
  assign pb_i[0] = sda;
  assign pa_i[1] = sda;
  assign pb_i[1] = scl;
  for (genvar g = 0; g < 2; g++) begin : g_dev
    irs_target #(.REVISION_ID(REV), .PART_ID(PRT), .REVISION_ID_TWO(RV2), .LOT_LSB(LTL), .LOT_MSB(LTH))
    irs_target_inst (
      .clk(clk), .sys_rst(sys_rst), .pin_a_i(pa_i[g]), .pin_a_o(a_o[g]), .pin_a_oe(a_oe[g]),
      .pin_b_i(pb_i[g]), .pin_b_o(b_o[g]), .pin_b_oe(b_oe[g]), .raw_signal(raw_signal),
      .raw_valid(raw_valid), .function_enable(fe[g]), .low_threshold(lth[g]),
      .high_threshold(hth[g]), .address_settled(setl[g])
    );
  end
  irs_bus_ctrl irs_bus_ctrl_inst (.clk(clk), .scl_i(scl), .sda_i(sda), .scl_low(scl_low), .sda_low(sda_low));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // ****************************
  // reference model and checks
  // ****************************
  function automatic logic [7:0] rv(int a);
    case (a)
      8'h82: return 8'h1F;
      8'h8D: return 8'h40;
      8'h8E: return 8'h8F;
      8'h8F: return 8'h60;
      8'hAA: return 8'h02;
      8'hAB: return 8'h04;
      8'hAE: return 8'h3F;
      8'hD9: return 8'h50;
      8'h91: return REV;
      8'h92: return PRT;
      8'hA6: return RV2;
      8'hE5: return LTL;
      8'hE6: return LTH;
      default: return 8'h00;
    endcase
  endfunction
  function automatic int dix(logic [6:0] a);
    return (a == IRS_ADDR_SWAPPED) ? 1 : 0;
  endfunction
  task automatic chk_val(string nm, logic [13:0] e, logic [13:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ack(string nm, logic e, logic g);
    chk_val(nm, {13'h0, e}, {13'h0, g});
  endtask
  task automatic snd(string nm, logic [7:0] d, logic ea);
    logic [8:0] rx;
    irs_bus_ctrl_inst.xfer({d, 1'h1}, rx);
    chk_ack(nm, ea, ~rx[0]);
  endtask
  task automatic chk_outs();
    @(negedge clk);
    for (int d = 0; d < 2; d++) begin
      chk_val("function enable", {6'h0, mem[d][8'h80]}, {6'h0, fe[d]});
      chk_val("low threshold", lt[d], lth[d]);
      chk_val("high threshold", ht[d], hth[d]);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] p, logic [7:0] dq[$]);
    int d;
    d = dix(a);
    irs_bus_ctrl_inst.start();
    snd("write address ack", {a, 1'h0}, 1'h1);
    snd("pointer ack", p, 1'h1);
    foreach (dq[i]) begin
      snd("data ack", dq[i], 1'h1);
      if (rw[p]) mem[d][p] = dq[i];
      if (p == 8'h89) lt[d] = {dq[i][5:0], mem[d][8'h88]};
      if (p == 8'h8B) ht[d] = {dq[i][5:0], mem[d][8'h8A]};
      p++;
    end
    ptr[d] = p;
    irs_bus_ctrl_inst.stop();
    chk_outs();
  endtask
  task automatic rd(logic [6:0] a, bit setp, logic [7:0] p, int n);
    int d;
    logic [8:0] rx;
    d = dix(a);
    irs_bus_ctrl_inst.start();
    if (setp) begin
      snd("write address ack", {a, 1'h0}, 1'h1);
      snd("pointer ack", p, 1'h1);
      ptr[d] = p;
      irs_bus_ctrl_inst.start();
    end
    snd("read address ack", {a, 1'h1}, 1'h1);
    for (int i = 0; i < n; i++) begin
      irs_bus_ctrl_inst.xfer({8'hFF, 1'(i == n - 1)}, rx);
      chk_val("read data", {6'h0, mem[d][ptr[d]]}, {6'h0, rx[8:1]});
      if (ptr[d] == 8'h9B) mem[d][8'h9B][0] = 1'h0;
      ptr[d]++;
    end
    irs_bus_ctrl_inst.stop();
  endtask
  task automatic pulse();
    int r;
    @(negedge clk);
    raw_signal = 14'($random(seed));
    raw_valid = 1'h1;
    for (int d = 0; d < 2; d++) begin
      r = int'(raw_signal) - $signed({mem[d][8'hC1][0], mem[d][8'hC0]});
      r = (r < 0) ? 0 : ((r > 16'h3FFF) ? 16'h3FFF : r);
      {mem[d][8'h9D], mem[d][8'h9C]} = 16'(r);
      mem[d][8'h9B][0] = 1'h1;
    end
    @(negedge clk);
    raw_valid = 1'h0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************
  // scenarios
  // ****************************
  initial begin
    sys_rst = 1'h1;
    raw_signal = 14'h0;
    raw_valid = 1'h0;
    for (int a = 0; a < 256; a++) begin
      rw[a] = 1'b0;
      mem[0][a] = rv(a);
      mem[1][a] = rv(a);
    end
    foreach (rwl[i]) rw[rwl[i]] = 1'b1;
    ptr = '{8'h00, 8'h00};
    lt = '{14'h0, 14'h0};
    ht = '{14'h0, 14'h0};
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    repeat (6) @(negedge clk);
    chk_ack("settled early", 1'h0, setl[0]);
    irs_bus_ctrl_inst.start();
    snd("dummy ack", {IRS_ADDR_NORMAL, 1'h0}, 1'h0);
    irs_bus_ctrl_inst.stop();
    chk_ack("settled normal", 1'h1, setl[0]);
    chk_ack("settled swapped", 1'h1, setl[1]);
    wr(IRS_ADDR_NORMAL, IRS_FACTORY_TEST_KEY, '{IRS_KEY_VALUE});
    wr(IRS_ADDR_SWAPPED, IRS_FACTORY_TEST_KEY, '{IRS_KEY_VALUE});
    rd(IRS_ADDR_NORMAL, 1'b1, 8'h80, 128);
    rd(IRS_ADDR_NORMAL, 1'b0, 8'h00, 1);
    // foreign address is ignored until the next start
    irs_bus_ctrl_inst.start();
    snd("foreign ack", 8'h54, 1'h0);
    irs_bus_ctrl_inst.stop();
    wr(IRS_ADDR_NORMAL, IRS_PART_CODE, '{8'h00, 8'hFF});
    rd(IRS_ADDR_NORMAL, 1'b1, IRS_REVISION_CODE, 3);
    wr(IRS_ADDR_NORMAL, IRS_LOW_THRESH_LSB, '{8'hCD});
    wr(IRS_ADDR_NORMAL, IRS_LOW_THRESH_MSB, '{8'hFF});
    wr(IRS_ADDR_NORMAL, IRS_HIGH_THRESH_LSB, '{8'h12, 8'h2B});
    repeat (32) q.push_back(8'($random(seed)));
    wr(IRS_ADDR_SWAPPED, 8'h80, q);
    rd(IRS_ADDR_SWAPPED, 1'b1, 8'h80, 32);
    rd(IRS_ADDR_NORMAL, 1'b1, 8'h80, 8);
    rd(IRS_ADDR_NORMAL, 1'b1, 8'h8D, 2);
    rd(IRS_ADDR_NORMAL, 1'b0, 8'h00, 2);
    repeat (3) begin
      wr(IRS_ADDR_NORMAL, IRS_XTALK_OFFSET_LSB, '{8'($random(seed)), 8'($random(seed))});
      pulse();
      rd(IRS_ADDR_NORMAL, 1'b1, IRS_DEVICE_STATUS, 3);
      rd(IRS_ADDR_NORMAL, 1'b1, IRS_DEVICE_STATUS, 1);
    end
    // fast then standard bus rate
    irs_bus_ctrl_inst.hp = 156;
    rd(IRS_ADDR_NORMAL, 1'b1, 8'h80, 1);
    irs_bus_ctrl_inst.hp = 625;
    rd(IRS_ADDR_NORMAL, 1'b0, 8'h00, 1);
    end_sim();
  end
  initial begin
    repeat (130000) @(posedge clk);
    n_fail++;
    $display("CHECK FAILED run length expected finish seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
